// ---- rtl/bss_pkg.sv ----
// Shared constants, commands and state types for the branch and skip unit
package bss_pkg;
  localparam int PC_W = 16;
  localparam int CYC_W = 2;
  localparam int IO_ADDR_W = 5;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;
  localparam logic [7:0] STATUS_FLAGS_REGISTER_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
  localparam logic [PC_W-1:0] SKIP_ONE_WORD = 16'h0002;
  localparam logic [PC_W-1:0] SKIP_TWO_WORDS = 16'h0003;
  localparam logic [CYC_W-1:0] CYC_ONE = 2'h1;
  localparam logic [CYC_W-1:0] CYC_TWO = 2'h2;
  localparam logic [CYC_W-1:0] CYC_THREE = 2'h3;
  // Status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam int MSB = 7;
  localparam int NIB_MSB = 3;

  typedef enum logic [5:0] {
    OP_NONE,
    OP_RELATIVE_JUMP, OP_INDIRECT_JUMP,
    OP_RELATIVE_SUBROUTINE_CALL, OP_INDIRECT_SUBROUTINE_CALL,
    OP_SUBROUTINE_EXIT_POP,
    OP_COMPARE_SKIP_IF_EQUAL, OP_COMPARE_REGISTERS,
    OP_COMPARE_WITH_CARRY_IN, OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_ON_EQUAL, OP_BRANCH_ON_UNEQUAL,
    OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_SAME_OR_HIGHER, OP_BRANCH_ON_LOWER,
    OP_BRANCH_MINUS, OP_BRANCH_PLUS,
    OP_BRANCH_SIGNED_GREATER_EQUAL, OP_BRANCH_SIGNED_LESS,
    OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR,
    OP_BRANCH_TRANSFER_SET, OP_BRANCH_TRANSFER_CLEAR,
    OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED,
    OP_IO_BIT_SET_OP, OP_IO_BIT_CLEAR_OP,
    OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT
  } bss_op_e;

  typedef struct packed {
    bss_op_e op;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [7:0] io_val;
    logic [11:0] offset;
    logic [PC_W-1:0] z_ptr;
    logic [PC_W-1:0] stack_val;
    logic next_two_word;
  } bss_cmd_s;

  typedef enum logic {ST_IDLE, ST_WAIT} bss_state_e;

  typedef struct packed {
    bss_state_e st;
    logic [CYC_W-1:0] cnt;
    logic [PC_W-1:0] pc;
    logic [7:0] status_flags_register;
    logic busy;
    logic done;
    logic [CYC_W-1:0] cycles;
    logic push;
    logic [PC_W-1:0] push_data;
    logic pop;
    logic io_we;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [7:0] io_data;
    logic res_we;
    logic [7:0] res;
  } bss_regs_s;
endpackage : bss_pkg

// ---- rtl/bss_exec.sv ----
// Branch, skip, compare, bit and shift execution unit of the 8-bit core
`timescale 1ns/1ps
module bss_exec (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Instruction request
  input wire logic cmd_valid_i,
  input bss_pkg::bss_cmd_s cmd_i,
  // Flag load from the rest of the core
  input wire logic status_flags_register_we_i,
  input wire logic [7:0] status_flags_register_wdata_i,
  // Program flow state
  output logic [bss_pkg::PC_W-1:0] pc_o,
  output logic [7:0] status_flags_register_o,
  output logic busy_o,
  output logic done_o,
  output logic [bss_pkg::CYC_W-1:0] cycles_o,
  // Stack
  output logic push_o,
  output logic [bss_pkg::PC_W-1:0] push_data_o,
  output logic pop_o,
  // I/O register write
  output logic io_we_o,
  output logic [bss_pkg::IO_ADDR_W-1:0] io_addr_o,
  output logic [7:0] io_data_o,
  // Shift result write-back
  output logic res_we_o,
  output logic [7:0] res_o
);
  import bss_pkg::*;

  bss_regs_s r_r;
  bss_regs_s r_nxt;

  function automatic logic [7:0] cmp_flags(
    input logic [7:0] d, input logic [7:0] s, input logic cin,
    input logic keep_z, input logic [7:0] f);
    logic [7:0] res;
    logic [7:0] o;
    res = d - s - {7'h00, cin};
    o = f;
    o[FLAG_H] = (~d[NIB_MSB] & s[NIB_MSB]) | (s[NIB_MSB] & res[NIB_MSB]) |
                (res[NIB_MSB] & ~d[NIB_MSB]);
    o[FLAG_V] = (d[MSB] & ~s[MSB] & ~res[MSB]) |
                (~d[MSB] & s[MSB] & res[MSB]);
    o[FLAG_N] = res[MSB];
    o[FLAG_C] = (~d[MSB] & s[MSB]) | (s[MSB] & res[MSB]) |
                (res[MSB] & ~d[MSB]);
    // Carry-in compare only keeps Z set across a multi-byte chain
    o[FLAG_Z] = (res == 8'h00) & (~keep_z | f[FLAG_Z]);
    o[FLAG_S] = o[FLAG_N] ^ o[FLAG_V];
    return o;
  endfunction : cmp_flags

  function automatic logic [7:0] shift_flags(
    input logic [7:0] res, input logic cout, input logic [7:0] f);
    logic [7:0] o;
    o = f;
    o[FLAG_C] = cout;
    o[FLAG_N] = res[MSB];
    o[FLAG_V] = res[MSB] ^ cout;
    o[FLAG_Z] = (res == 8'h00);
    o[FLAG_S] = o[FLAG_N] ^ o[FLAG_V];
    return o;
  endfunction : shift_flags

  function automatic logic [PC_W-1:0] sext12(input logic [11:0] k);
    return {{(PC_W-12){k[11]}}, k};
  endfunction : sext12

  function automatic logic [PC_W-1:0] sext7(input logic [6:0] k);
    return {{(PC_W-7){k[6]}}, k};
  endfunction : sext7

  function automatic logic branch_taken(
    input bss_op_e op, input logic [2:0] b, input logic [7:0] f);
    logic t;
    t = 1'b0;
    case (op)
      OP_BRANCH_FLAG_SET: t = f[b];
      OP_BRANCH_FLAG_CLEAR: t = ~f[b];
      OP_BRANCH_ON_EQUAL: t = f[FLAG_Z];
      OP_BRANCH_ON_UNEQUAL: t = ~f[FLAG_Z];
      OP_BRANCH_CARRY_SET, OP_BRANCH_ON_LOWER: t = f[FLAG_C];
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: begin
        t = ~f[FLAG_C];
      end
      OP_BRANCH_SIGNED_GREATER_EQUAL: begin
        t = ~(f[FLAG_N] ^ f[FLAG_V]);
      end
      OP_BRANCH_SIGNED_LESS: t = f[FLAG_N] ^ f[FLAG_V];
      OP_BRANCH_MINUS: t = f[FLAG_N];
      OP_BRANCH_PLUS: t = ~f[FLAG_N];
      OP_BRANCH_HALF_CARRY_SET: t = f[FLAG_H];
      OP_BRANCH_HALF_CARRY_CLEAR: t = ~f[FLAG_H];
      OP_BRANCH_TRANSFER_SET: t = f[FLAG_T];
      OP_BRANCH_TRANSFER_CLEAR: t = ~f[FLAG_T];
      OP_BRANCH_OVERFLOW_SET: t = f[FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR: t = ~f[FLAG_V];
      OP_BRANCH_IRQ_ENABLED: t = f[FLAG_I];
      OP_BRANCH_IRQ_DISABLED: t = ~f[FLAG_I];
      default: t = 1'b0;
    endcase
    return t;
  endfunction : branch_taken

  function automatic logic is_branch(input bss_op_e op);
    return (op >= OP_BRANCH_FLAG_SET) && (op <= OP_BRANCH_IRQ_DISABLED);
  endfunction : is_branch

  always_comb begin
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] skip_pc;
    logic [CYC_W-1:0] skip_cyc;
    logic [CYC_W-1:0] cyc;
    logic skip;
    logic [7:0] sh;
    pc_inc = r_r.pc + PC_STEP;
    // Skip length follows the size of the instruction passed over
    skip_pc = r_r.pc + (cmd_i.next_two_word ? SKIP_TWO_WORDS : SKIP_ONE_WORD);
    skip_cyc = cmd_i.next_two_word ? CYC_THREE : CYC_TWO;
    cyc = CYC_ONE;
    skip = 1'b0;
    sh = 8'h00;
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    r_nxt.push = 1'b0;
    r_nxt.pop = 1'b0;
    r_nxt.io_we = 1'b0;
    r_nxt.res_we = 1'b0;
    case (r_r.st)
      ST_WAIT: begin
        if (r_r.cnt == CYC_ONE) begin
          r_nxt.st = ST_IDLE;
          r_nxt.busy = 1'b0;
          r_nxt.done = 1'b1;
        end else begin
          r_nxt.cnt = r_r.cnt - CYC_ONE;
        end
      end
      ST_IDLE: begin
        if (cmd_valid_i) begin
          r_nxt.pc = pc_inc;
          case (cmd_i.op)
            OP_RELATIVE_JUMP: begin
              r_nxt.pc = pc_inc + sext12(cmd_i.offset);
              cyc = CYC_TWO;
            end
            OP_RELATIVE_SUBROUTINE_CALL: begin
              r_nxt.push = 1'b1;
              r_nxt.push_data = pc_inc;
              r_nxt.pc = pc_inc + sext12(cmd_i.offset);
              cyc = CYC_THREE;
            end
            OP_INDIRECT_JUMP: begin
              r_nxt.pc = cmd_i.z_ptr;
              cyc = CYC_TWO;
            end
            OP_INDIRECT_SUBROUTINE_CALL: begin
              r_nxt.push = 1'b1;
              r_nxt.push_data = pc_inc;
              r_nxt.pc = cmd_i.z_ptr;
              cyc = CYC_THREE;
            end
            OP_SUBROUTINE_EXIT_POP: begin
              r_nxt.pop = 1'b1;
              r_nxt.pc = cmd_i.stack_val;
              cyc = CYC_THREE;
            end
            OP_COMPARE_SKIP_IF_EQUAL: begin
              skip = (cmd_i.rd_val == cmd_i.rr_val);
            end
            OP_COMPARE_REGISTERS: begin
              r_nxt.status_flags_register = cmp_flags(cmd_i.rd_val, cmd_i.rr_val, 1'b0, 1'b0,
                                     r_r.status_flags_register);
            end
            OP_COMPARE_WITH_CARRY_IN: begin
              r_nxt.status_flags_register = cmp_flags(cmd_i.rd_val, cmd_i.rr_val,
                                     r_r.status_flags_register[FLAG_C], 1'b1, r_r.status_flags_register);
            end
            OP_COMPARE_IMMEDIATE: begin
              r_nxt.status_flags_register = cmp_flags(cmd_i.rd_val, cmd_i.imm, 1'b0, 1'b0,
                                     r_r.status_flags_register);
            end
            OP_SKIP_REG_BIT_CLEAR: skip = ~cmd_i.rr_val[cmd_i.bit_sel];
            OP_SKIP_REG_BIT_SET: skip = cmd_i.rr_val[cmd_i.bit_sel];
            OP_SKIP_IO_BIT_CLEAR: skip = ~cmd_i.io_val[cmd_i.bit_sel];
            OP_SKIP_IO_BIT_SET: skip = cmd_i.io_val[cmd_i.bit_sel];
            OP_IO_BIT_SET_OP, OP_IO_BIT_CLEAR_OP: begin
              r_nxt.io_we = 1'b1;
              r_nxt.io_addr = cmd_i.io_addr;
              r_nxt.io_data = cmd_i.io_val;
              r_nxt.io_data[cmd_i.bit_sel] =
                (cmd_i.op == OP_IO_BIT_SET_OP);
              cyc = CYC_TWO;
            end
            OP_LOGICAL_LEFT_SHIFT: begin
              sh = {cmd_i.rd_val[MSB-1:0], 1'b0};
              r_nxt.res = sh;
              r_nxt.res_we = 1'b1;
              r_nxt.status_flags_register = shift_flags(sh, cmd_i.rd_val[MSB], r_r.status_flags_register);
            end
            OP_LOGICAL_RIGHT_SHIFT: begin
              sh = {1'b0, cmd_i.rd_val[MSB:1]};
              r_nxt.res = sh;
              r_nxt.res_we = 1'b1;
              r_nxt.status_flags_register = shift_flags(sh, cmd_i.rd_val[0], r_r.status_flags_register);
            end
            default: begin
              if (is_branch(cmd_i.op) &&
                  branch_taken(cmd_i.op, cmd_i.bit_sel, r_r.status_flags_register)) begin
                r_nxt.pc = pc_inc + sext7(cmd_i.offset[6:0]);
                cyc = CYC_TWO;
              end
            end
          endcase
          if (skip) begin
            r_nxt.pc = skip_pc;
            cyc = skip_cyc;
          end
          r_nxt.cycles = cyc;
          if (cyc == CYC_ONE) begin
            r_nxt.done = 1'b1;
          end else begin
            r_nxt.st = ST_WAIT;
            r_nxt.busy = 1'b1;
            r_nxt.cnt = cyc - CYC_ONE;
          end
        end else if (status_flags_register_we_i) begin
          r_nxt.status_flags_register = status_flags_register_wdata_i;
        end
      end
      default: begin
        r_nxt.st = ST_IDLE;
        r_nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r_r <= '{st: ST_IDLE, cnt: '0, pc: PC_RST, status_flags_register: STATUS_FLAGS_REGISTER_RST,
               busy: 1'b0, done: 1'b0, cycles: '0, push: 1'b0,
               push_data: '0, pop: 1'b0, io_we: 1'b0, io_addr: '0,
               io_data: 8'h00, res_we: 1'b0, res: 8'h00};
    end else if (ce_i) begin
      r_r <= r_nxt;
    end
  end

  assign pc_o = r_r.pc;
  assign status_flags_register_o = r_r.status_flags_register;
  assign busy_o = r_r.busy;
  assign done_o = r_r.done;
  assign cycles_o = r_r.cycles;
  assign push_o = r_r.push;
  assign push_data_o = r_r.push_data;
  assign pop_o = r_r.pop;
  assign io_we_o = r_r.io_we;
  assign io_addr_o = r_r.io_addr;
  assign io_data_o = r_r.io_data;
  assign res_we_o = r_r.res_we;
  assign res_o = r_r.res;
endmodule : bss_exec

// ---- test/bss_exec_monitor.sv ----
// Port checker for the branch and skip unit
`timescale 1ns/1ps
module bss_exec_monitor (
  // Clock, reset, requests
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic cmd_valid_i,
  input bss_pkg::bss_cmd_s cmd_i,
  // Observed outputs
  input wire logic [bss_pkg::PC_W-1:0] pc_o,
  input wire logic [7:0] status_flags_register_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [bss_pkg::CYC_W-1:0] cycles_o,
  input wire logic push_o,
  input wire logic [bss_pkg::PC_W-1:0] push_data_o,
  input wire logic pop_o,
  input wire logic io_we_o,
  input wire logic [bss_pkg::IO_ADDR_W-1:0] io_addr_o,
  input wire logic [7:0] io_data_o,
  input wire logic res_we_o,
  input wire logic [7:0] res_o
);
  import bss_pkg::*;
  logic acc;
  logic [PC_W-1:0] jk;
  logic [PC_W-1:0] bk;
  assign acc = ce_i && cmd_valid_i && !busy_o;
  assign jk = {{4{cmd_i.offset[11]}}, cmd_i.offset};
  assign bk = {{9{cmd_i.offset[6]}}, cmd_i.offset[6:0]};
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rel_jump: assert property (
    acc && cmd_i.op == OP_RELATIVE_JUMP |=> cycles_o == CYC_TWO &&
    pc_o == $past(pc_o) + 16'h0001 + $past(jk)) else $error("rel jump");
  a_ind_jump: assert property (
    acc && cmd_i.op == OP_INDIRECT_JUMP |=>
    pc_o == $past(cmd_i.z_ptr) && $stable(status_flags_register_o)) else $error("ind jump");
  a_call_push: assert property (
    acc && cmd_i.op == OP_INDIRECT_SUBROUTINE_CALL |=> push_o &&
    push_data_o == $past(pc_o) + 16'h0001 && pc_o == $past(cmd_i.z_ptr))
    else $error("call push");
  a_ret_pop: assert property (
    acc && cmd_i.op == OP_SUBROUTINE_EXIT_POP |=> pop_o && busy_o &&
    pc_o == $past(cmd_i.stack_val) ##2 done_o && !busy_o)
    else $error("return pop");
  a_three_len: assert property (
    $rose(busy_o) && cycles_o == CYC_THREE |-> ##1 busy_o ##1
    (done_o && !busy_o)) else $error("three cycle span");
  a_cmp_flags: assert property (
    acc && cmd_i.op == OP_COMPARE_REGISTERS |=> done_o && !res_we_o &&
    status_flags_register_o[7:6] == $past(status_flags_register_o[7:6]) &&
    status_flags_register_o[FLAG_C] == ($past(cmd_i.rd_val) < $past(cmd_i.rr_val)))
    else $error("compare flags");
  a_io_set: assert property (
    acc && cmd_i.op == OP_IO_BIT_SET_OP |=> io_we_o &&
    io_addr_o == $past(cmd_i.io_addr) && io_data_o ==
    ($past(cmd_i.io_val) | (8'h01 << $past(cmd_i.bit_sel))))
    else $error("io bit set");
  a_shift_left: assert property (
    acc && cmd_i.op == OP_LOGICAL_LEFT_SHIFT |=> res_we_o &&
    res_o == {$past(cmd_i.rd_val[6:0]), 1'b0} &&
    status_flags_register_o[FLAG_C] == $past(cmd_i.rd_val[7])) else $error("shift left");
  a_flag_branch: assert property (
    acc && cmd_i.op == OP_BRANCH_FLAG_SET && status_flags_register_o[cmd_i.bit_sel] |=>
    cycles_o == CYC_TWO && pc_o == $past(pc_o) + 16'h0001 + $past(bk))
    else $error("flag branch");
  c_ret: cover property (acc && cmd_i.op == OP_SUBROUTINE_EXIT_POP);
  c_three: cover property ($rose(busy_o) && cycles_o == CYC_THREE);
  c_io: cover property (io_we_o);
endmodule : bss_exec_monitor

// ---- test/bss_mem_model.sv ----
// Stack and I/O register space beside the execution unit
`timescale 1ns/1ps
module bss_mem_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Stack
  input wire logic push_i,
  input wire logic [bss_pkg::PC_W-1:0] push_data_i,
  input wire logic pop_i,
  output logic [bss_pkg::PC_W-1:0] top_o,
  // I/O space
  input wire logic io_we_i,
  input wire logic [bss_pkg::IO_ADDR_W-1:0] io_addr_i,
  input wire logic [7:0] io_data_i,
  input wire logic [bss_pkg::IO_ADDR_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  import bss_pkg::*;
  logic [PC_W-1:0] stk [8];
  logic [2:0] sp;
  logic [7:0] io [32];
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sp <= 3'h0;
      foreach (io[a]) io[a] <= 8'ha5;
    end else begin
      if (push_i) begin
        stk[sp] <= push_data_i;
        sp <= sp + 3'h1;
      end else if (pop_i) begin
        sp <= sp - 3'h1;
      end
      if (io_we_i) io[io_addr_i] <= io_data_i;
    end
  end
  assign top_o = stk[sp - 3'h1];
  assign rd_data_o = io[rd_addr_i];
endmodule : bss_mem_model

// ---- test/bss_exec_test.sv ----
// Self-checking bench for the branch and skip unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module bss_exec_test;
  import bss_pkg::*;
  logic sys_clk_i = 0, rst_n_i = 0, ce_i = 1, cmd_valid_i = 0;
  logic status_flags_register_we_i = 0, push_o, pop_o, io_we_o, res_we_o, busy_o, done_o;
  logic pu, po, iw;
  bss_cmd_s cmd_i = '0;
  logic [7:0] status_flags_register_wdata_i = 8'h00, status_flags_register_o, io_data_o, res_o, rd_d, sv;
  logic [PC_W-1:0] pc_o, push_data_o, top, pm;
  logic [CYC_W-1:0] cycles_o;
  logic [IO_ADDR_W-1:0] io_addr_o;
  logic [7:0] fm [20] = '{8'h40, 8'h40, 8'h02, 8'h02, 8'h01, 8'h01, 8'h01,
    8'h01, 8'h04, 8'h04, 8'h14, 8'h14, 8'h20, 8'h20, 8'h40, 8'h40, 8'h08,
    8'h08, 8'h80, 8'h80};
  logic [19:0] pol = 20'h55995;
  logic tk;
  int error_cnt = 0, n_tests = 0, n;
  always #5 sys_clk_i = ~sys_clk_i;
  bss_exec dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .status_flags_register_we_i(status_flags_register_we_i),
    .status_flags_register_wdata_i(status_flags_register_wdata_i), .pc_o(pc_o), .status_flags_register_o(status_flags_register_o),
    .busy_o(busy_o), .done_o(done_o), .cycles_o(cycles_o),
    .push_o(push_o), .push_data_o(push_data_o), .pop_o(pop_o),
    .io_we_o(io_we_o), .io_addr_o(io_addr_o), .io_data_o(io_data_o),
    .res_we_o(res_we_o), .res_o(res_o));
  bss_mem_model mem_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .push_i(push_o), .push_data_i(push_data_o), .pop_i(pop_o),
    .top_o(top), .io_we_i(io_we_o), .io_addr_i(io_addr_o),
    .io_data_i(io_data_o), .rd_addr_i(5'h05), .rd_data_o(rd_d));
  task complete_run;
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  // Called just after a falling edge while the unit is idle
  task flags(input logic [7:0] v);
    status_flags_register_we_i = 1;
    status_flags_register_wdata_i = v;
    @(negedge sys_clk_i);
    status_flags_register_we_i = 0;
    `CHK("status_flags_register_load", v, status_flags_register_o)
  endtask : flags
  task exec(input bss_op_e op, input logic [PC_W-1:0] epc,
    input logic [CYC_W-1:0] ec);
    cmd_i.op = op;
    cmd_valid_i = 1;
    @(negedge sys_clk_i);
    cmd_valid_i = 0;
    pu = push_o;
    po = pop_o;
    iw = io_we_o;
    n = 1;
    while (done_o !== 1'b1 && n < 6) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 6) begin
      error_cnt++;
      complete_run;
    end
    `CHK("cycles", ec, cycles_o)
    `CHK("span", ec, n[1:0])
    `CHK("pc", epc, pc_o)
    pm = epc;
  endtask : exec
  initial begin
    repeat (8) @(negedge sys_clk_i);
    rst_n_i = 1;
    `CHK("pc_rst", PC_RST, pc_o)
    cmd_i.offset = 12'h0ff;
    exec(OP_RELATIVE_JUMP, 16'h0100, CYC_TWO);
    cmd_i.offset = 12'hffe;
    exec(OP_RELATIVE_SUBROUTINE_CALL, 16'h00ff, CYC_THREE);
    `CHK("relative_subroutine_call_push", 1'b1, pu)
    cmd_i.z_ptr = 16'h1234;
    exec(OP_INDIRECT_JUMP, 16'h1234, CYC_TWO);
    cmd_i.z_ptr = 16'h2000;
    exec(OP_INDIRECT_SUBROUTINE_CALL, 16'h2000, CYC_THREE);
    `CHK("stack_top", 16'h1235, top)
    cmd_i.stack_val = top;
    exec(OP_SUBROUTINE_EXIT_POP, 16'h1235, CYC_THREE);
    `CHK("ret_pop", 1'b1, po)
    flags(8'hc0);
    cmd_i.rd_val = 8'h00;
    cmd_i.rr_val = 8'h01;
    exec(OP_COMPARE_REGISTERS, pm + 16'h0001, CYC_ONE);
    `CHK("cp_flags", 8'he5, status_flags_register_o & 8'hef)
    cmd_i.rd_val = 8'h05;
    cmd_i.rr_val = 8'h04;
    exec(OP_COMPARE_WITH_CARRY_IN, pm + 16'h0001, CYC_ONE);
    `CHK("cpc_flags", 8'hc0, status_flags_register_o & 8'hef)
    cmd_i.rd_val = 8'h80;
    cmd_i.imm = 8'h01;
    exec(OP_COMPARE_IMMEDIATE, pm + 16'h0001, CYC_ONE);
    `CHK("cpi_flags", 8'he8, status_flags_register_o & 8'hef)
    sv = status_flags_register_o;
    cmd_i.next_two_word = 1;
    cmd_i.rr_val = 8'h80;
    exec(OP_COMPARE_SKIP_IF_EQUAL, pm + 16'h0003, CYC_THREE);
    cmd_i.rr_val = 8'h81;
    exec(OP_COMPARE_SKIP_IF_EQUAL, pm + 16'h0001, CYC_ONE);
    cmd_i.next_two_word = 0;
    cmd_i.rd_val = 8'h04;
    cmd_i.rr_val = 8'h04;
    cmd_i.bit_sel = 3'h2;
    exec(OP_SKIP_REG_BIT_CLEAR, pm + 16'h0001, CYC_ONE);
    exec(OP_SKIP_REG_BIT_SET, pm + 16'h0002, CYC_TWO);
    cmd_i.io_addr = 5'h05;
    cmd_i.io_val = rd_d;
    cmd_i.bit_sel = 3'h1;
    exec(OP_SKIP_IO_BIT_SET, pm + 16'h0001, CYC_ONE);
    cmd_i.next_two_word = 1;
    exec(OP_SKIP_IO_BIT_CLEAR, pm + 16'h0003, CYC_THREE);
    exec(OP_IO_BIT_SET_OP, pm + 16'h0001, CYC_TWO);
    `CHK("io_we", 1'b1, iw)
    `CHK("io_set", 8'ha7, rd_d)
    cmd_i.io_val = rd_d;
    cmd_i.bit_sel = 3'h0;
    exec(OP_IO_BIT_CLEAR_OP, pm + 16'h0001, CYC_TWO);
    `CHK("io_clr", 8'ha6, rd_d)
    `CHK("flags_kept", sv, status_flags_register_o)
    flags(8'h00);
    cmd_i.rd_val = 8'h81;
    exec(OP_LOGICAL_LEFT_SHIFT, pm + 16'h0001, CYC_ONE);
    `CHK("lsl", 12'h902, {status_flags_register_o[3:0], res_o})
    cmd_i.rd_val = 8'h01;
    exec(OP_LOGICAL_RIGHT_SHIFT, pm + 16'h0001, CYC_ONE);
    `CHK("lsr", 12'hb00, {status_flags_register_o[3:0], res_o})
    // A request while the enable is low must leave all state frozen
    ce_i = 0;
    cmd_i.op = OP_RELATIVE_JUMP;
    cmd_valid_i = 1;
    repeat (2) @(negedge sys_clk_i);
    `CHK("ce_hold", pm, pc_o)
    cmd_valid_i = 0;
    ce_i = 1;
    @(negedge sys_clk_i);
    `CHK("ce_resume", pm, pc_o)
    cmd_i.offset = 12'h07d;
    cmd_i.bit_sel = 3'h6;
    for (int i = 0; i < 20; i++) begin
      for (int b = 0; b < 2; b++) begin
        flags(b[0] ? fm[i] : 8'h00);
        tk = (b[0] == pol[i]);
        exec(bss_op_e'(int'(OP_BRANCH_FLAG_SET) + i),
          tk ? pm - 16'h0002 : pm + 16'h0001,
          tk ? CYC_TWO : CYC_ONE);
      end
    end
    complete_run;
  end
endmodule : bss_exec_test
bind bss_exec bss_exec_monitor mon_u (.sys_clk_i, .rst_n_i, .ce_i,
  .cmd_valid_i, .cmd_i, .pc_o, .status_flags_register_o, .busy_o, .done_o, .cycles_o,
  .push_o, .push_data_o, .pop_o, .io_we_o, .io_addr_o, .io_data_o,
  .res_we_o, .res_o);
